// file: src/alu_pkg.sv
// Package with field positions, operation codes and timing counts for the compact ALU decoder.
// Function
// [RULE_01] Immediate format: imm8 in [7:0], register in [10:8], opcode in [12:11].
// [RULE_02] Immediate opcode 00 writes the zero-extended immediate to the register.
// [RULE_03] Immediate opcode 01 compares register with immediate, flags only.
// [RULE_04] Immediate opcode 10 adds immediate to register and writes back.
// [RULE_05] Immediate opcode 11 subtracts immediate from register and writes back.
// [RULE_06] Every operation of both formats updates the condition flags.
// [RULE_07] Each operation takes as many cycles as its full-width equivalent.
// [RULE_08] Register format: destination in [2:0], second source in [5:3], 4-bit opcode.
// [RULE_09] Codes 0000, 1100, 1110 do AND, OR, bit clear; 1111 inverts source.
// [RULE_10] Code 0001 writes exclusive OR of destination and second source.
// [RULE_11] Codes 0010, 0011, 0100, 0111 shift left, right, arithmetic, rotate by source.
// [RULE_12] Code 0101 adds destination, source and carry.
// [RULE_13] Code 0110 subtracts source and inverted carry from destination.
// [RULE_14] Code 1000 sets flags from AND without writing.
// [RULE_15] Code 1001 writes zero minus second source.
// [RULE_16] Code 1010 sets flags from destination minus source without writing.
// [RULE_17] Code 1011 sets flags from destination plus source without writing.
// [RULE_18] Code 1101 writes low 32 bits of source times destination.
// [RULE_19] Compare and test operations suppress the register write enable.
package alu_pkg;
  localparam int IMM_LSB      = 0;
  localparam int IMM_W        = 8;
  localparam int IMM_RD_LSB   = 8;
  localparam int IMM_OP_LSB   = 11;
  localparam int REG_RD_LSB   = 0;
  localparam int REG_RS_LSB   = 3;
  localparam int REG_OP_LSB   = 6;
  localparam int FMT_IMM_LSB  = 13;
  localparam int FMT_REG_LSB  = 10;
  localparam logic [2:0] FMT_IMM_CODE = 3'h1;
  localparam logic [5:0] FMT_REG_CODE = 6'h10;
  // Multiply early-termination step: 8 multiplier bits per internal cycle.
  localparam int MUL_STEP_BITS = 8;
  localparam logic [1:0] IMM_MOV = 2'h0;
  localparam logic [1:0] IMM_CMP = 2'h1;
  localparam logic [1:0] IMM_ADD = 2'h2;
  localparam logic [1:0] IMM_SUB = 2'h3;
  typedef enum logic [3:0] {
    OP_AND = 4'h0, OP_EOR_X = 4'h1, OP_SHL = 4'h2, OP_SHR = 4'h3,
    OP_SAR = 4'h4, OP_ADDC = 4'h5, OP_SUBC = 4'h6, OP_ROTR = 4'h7,
    OP_TEST = 4'h8, OP_NEGATE = 4'h9, OP_COMPARE = 4'ha, OP_COMPARE_NEG = 4'hb,
    OP_OR = 4'hc, OP_MULT = 4'hd, OP_BITCLR = 4'he, OP_MOVINV = 4'hf
  } reg_op_e;
  localparam logic [3:0] FLAGS_RESET = 4'h0;
endpackage

// file: src/alu_shifter.sv
// Register-specified shifter with carry-out for the register ALU format.
`timescale 1ns/1ps
module alu_shifter (
  // Operand and amount.
  input  wire logic [31:0] value,
  input  wire logic [7:0]  amount,
  input  wire logic [1:0]  kind,
  input  wire logic        carryIn,
  // Result.
  output logic      [31:0] result,
  output logic             carryOut
);
  logic [63:0] wide;
  logic [4:0]  rot;

  // Amounts of 32 and more follow register-shift semantics; zero leaves carry unchanged.
  always_comb begin
    result   = value;
    carryOut = carryIn;
    wide     = 64'h0;
    rot      = amount[4:0];
    if (amount != 8'h0) begin
      case (kind)
        2'h0: begin
          if (amount > 8'd32) begin
            result   = 32'h0;
            carryOut = 1'b0;
          end else begin
            wide     = {32'h0, value} << amount[5:0];
            result   = wide[31:0];
            carryOut = wide[32];
          end
        end
        2'h1: begin
          if (amount > 8'd32) begin
            result   = 32'h0;
            carryOut = 1'b0;
          end else begin
            wide     = {value, 32'h0} >> amount[5:0];
            result   = wide[63:32];
            carryOut = wide[31];
          end
        end
        2'h2: begin
          if (amount >= 8'd32) begin
            result   = {32{value[31]}};
            carryOut = value[31];
          end else begin
            wide     = $signed({value, 32'h0}) >>> amount[4:0];
            result   = wide[63:32];
            carryOut = wide[31];
          end
        end
        default: begin
          result   = (value >> rot) | (value << (6'd32 - {1'b0, rot}));
          carryOut = result[31];
        end
      endcase
    end
  end
endmodule

// file: src/compact_alu_op_decode.sv
// Decode and execute of the immediate and register ALU compressed formats.
`timescale 1ns/1ps
module compact_alu_op_decode
  import alu_pkg::*;
(
  // Clock and reset.
  input  wire logic        clk,
  input  wire logic        rst,
  // Instruction issue.
  input  wire logic        instrValid,
  input  wire logic [15:0] instr,
  output logic             instrReady,
  // Register file read ports, driven combinationally from the instruction.
  output logic [2:0]       rdAddr,
  output logic [2:0]       rsAddr,
  input  wire logic [31:0] rdData,
  input  wire logic [31:0] rsData,
  // Register file write port.
  output logic             wrEn,
  output logic [2:0]       wrAddr,
  output logic [31:0]      wrData,
  // Condition flags N, Z, C, V.
  output logic [3:0]       programStatusFlags,
  output logic             flagsUpdated,
  output logic             illegalFmt
);
  import alu_pkg::*;

  typedef enum logic [1:0] {IDLE, MUL_BUSY} state_e;

  typedef struct packed {
    state_e      state;
    logic [3:0]  flags;
    logic        wrEn;
    logic [2:0]  wrAddr;
    logic [31:0] wrData;
    logic        upd;
    logic        illegal;
    logic [2:0]  mulLeft;
    logic [31:0] mulRes;
  } state_s;

  state_s cur_q, nxt_d;

  logic        isImm, isReg;
  logic [1:0]  immOp;
  reg_op_e     regOp;
  logic [32:0] sum;
  logic [31:0] res, opA, opB, shRes;
  logic        cOut, vOut, doWrite, setsLogicC, shC;
  logic [2:0]  mulCycles;

  // Multiplier cycles depend on how many upper bytes are all zeros or all ones.
  function automatic logic [2:0] mul_cycles(input logic [31:0] m);
    if (m[31:8] == 24'h0 || m[31:8] == 24'hffffff) mul_cycles = 3'd1;
    else if (m[31:16] == 16'h0 || m[31:16] == 16'hffff) mul_cycles = 3'd2;
    else if (m[31:24] == 8'h0 || m[31:24] == 8'hff) mul_cycles = 3'd3;
    else mul_cycles = 3'd4;
  endfunction

  // Format decode of the two compressed forms.
  assign isImm  = instr[15:FMT_IMM_LSB] == FMT_IMM_CODE;
  assign isReg  = instr[15:FMT_REG_LSB] == FMT_REG_CODE;
  assign immOp  = instr[IMM_OP_LSB +: 2];                      // see [RULE_01]
  assign regOp  = reg_op_e'(instr[REG_OP_LSB +: 4]);           // see [RULE_08]
  assign rdAddr = isImm ? instr[IMM_RD_LSB +: 3] : instr[REG_RD_LSB +: 3]; // see [RULE_01]
  assign rsAddr = instr[REG_RS_LSB +: 3];                       // see [RULE_08]
  assign instrReady = cur_q.state == IDLE;
  assign mulCycles  = mul_cycles(rsData);

  // Shifter kinds are 0 left, 1 logical right, 2 arithmetic right and 3 rotate; each op
  // is matched by name except rotate, the default, since the opcodes do not map onto the kinds by plain arithmetic.
  alu_shifter u_shift (
    .value    (rdData),
    .amount   (rsData[7:0]),
    .kind     ((regOp == OP_SAR) ? 2'h2 : (regOp == OP_SHR) ? 2'h1 :
               (regOp == OP_SHL) ? 2'h0 : 2'h3),                       // see [RULE_11]
    .carryIn  (cur_q.flags[1]),
    .result   (shRes),
    .carryOut (shC)
  );

  // Arithmetic and logic result selection.
  always_comb begin
    opA        = rdData;
    opB        = 32'h0;
    sum        = 33'h0;
    res        = 32'h0;
    cOut       = cur_q.flags[1];
    vOut       = cur_q.flags[0];
    doWrite    = 1'b1;
    setsLogicC = 1'b0;
    if (isImm) begin
      opB = {24'h0, instr[IMM_LSB +: IMM_W]};                  // see [RULE_01]
      case (immOp)
        IMM_MOV: res = opB;                                    // see [RULE_02]
        IMM_ADD: begin
          sum = {1'b0, opA} + {1'b0, opB};                      // see [RULE_04]
          res = sum[31:0];
        end
        default: begin
          sum = {1'b0, opA} + {1'b0, ~opB} + 33'h1;             // see [RULE_05]
          res = sum[31:0];
          doWrite = immOp != IMM_CMP;                           // see [RULE_03] [RULE_19]
        end
      endcase
      if (immOp != IMM_MOV) begin
        cOut = sum[32];
        vOut = (opA[31] == (immOp == IMM_ADD ? opB[31] : ~opB[31])) && (res[31] != opA[31]);
      end
    end else begin
      opB = rsData;
      case (regOp)
        OP_AND, OP_TEST: res = opA & opB;                      // see [RULE_09] [RULE_14]
        OP_OR:      res = opA | opB;                           // see [RULE_09]
        OP_BITCLR:  res = opA & ~opB;                          // see [RULE_09]
        OP_MOVINV:  res = ~opB;                                // see [RULE_09]
        OP_EOR_X:   res = opA ^ opB;                           // see [RULE_10]
        OP_SHL, OP_SHR, OP_SAR, OP_ROTR: begin
          res = shRes;                                         // see [RULE_11]
          setsLogicC = 1'b1;
        end
        OP_ADDC: sum = {1'b0, opA} + {1'b0, opB} + {32'h0, cur_q.flags[1]}; // see [RULE_12]
        OP_SUBC: sum = {1'b0, opA} + {1'b0, ~opB} + {32'h0, cur_q.flags[1]}; // see [RULE_13]
        OP_NEGATE: begin
          opA = 32'h0;
          sum = {1'b0, ~opB} + 33'h1;                           // see [RULE_15]
        end
        OP_COMPARE: sum = {1'b0, opA} + {1'b0, ~opB} + 33'h1;  // see [RULE_16]
        OP_COMPARE_NEG: sum = {1'b0, opA} + {1'b0, opB};       // see [RULE_17]
        default: res = opB * opA;                              // see [RULE_18]
      endcase
      case (regOp)
        OP_ADDC, OP_COMPARE_NEG: begin
          res  = sum[31:0];
          cOut = sum[32];
          vOut = (opA[31] == opB[31]) && (res[31] != opA[31]);
        end
        OP_SUBC, OP_NEGATE, OP_COMPARE: begin
          res  = sum[31:0];
          cOut = sum[32];
          vOut = (opA[31] != opB[31]) && (res[31] != opA[31]);
        end
        default: cOut = setsLogicC ? shC : cur_q.flags[1];
      endcase
      // Flag-only operations leave the destination untouched.
      doWrite = !(regOp == OP_TEST || regOp == OP_COMPARE || regOp == OP_COMPARE_NEG); // see [RULE_19]
    end
  end

  // Next-state logic: single-cycle ops retire at once, multi-cycle multiply holds issue busy.
  always_comb begin
    nxt_d         = cur_q;
    nxt_d.wrEn    = 1'b0;
    nxt_d.upd     = 1'b0;
    nxt_d.illegal = 1'b0;
    case (cur_q.state)
      IDLE: begin
        if (instrValid && !(isImm || isReg)) begin
          nxt_d.illegal = 1'b1;
        end else if (instrValid && isReg && regOp == OP_MULT && mulCycles != 3'd1) begin
          // Multiply is held back so its latency matches the full-width form.
          nxt_d.state   = MUL_BUSY;                            // see [RULE_07]
          nxt_d.mulLeft = mulCycles - 3'd1;
          nxt_d.mulRes  = res;
          nxt_d.wrAddr  = rdAddr;
        end else if (instrValid) begin
          nxt_d.wrEn   = doWrite;                              // see [RULE_19]
          nxt_d.wrAddr = rdAddr;
          nxt_d.wrData = res;
          nxt_d.flags  = {res[31], res == 32'h0, cOut, vOut};  // see [RULE_06]
          nxt_d.upd    = 1'b1;                                 // see [RULE_06]
        end
      end
      MUL_BUSY: begin
        nxt_d.mulLeft = cur_q.mulLeft - 3'd1;
        if (cur_q.mulLeft == 3'd1) begin
          nxt_d.state  = IDLE;                                 // see [RULE_07]
          nxt_d.wrEn   = 1'b1;
          nxt_d.wrData = cur_q.mulRes;
          nxt_d.flags  = {cur_q.mulRes[31], cur_q.mulRes == 32'h0, cur_q.flags[1:0]}; // see [RULE_06]
          nxt_d.upd    = 1'b1;
        end
      end
      default: nxt_d.state = IDLE;
    endcase
  end

  // State register.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cur_q <= '{state: IDLE, flags: FLAGS_RESET, wrEn: 1'b0, wrAddr: 3'h0,
                 wrData: 32'h0, upd: 1'b0, illegal: 1'b0, mulLeft: 3'h0, mulRes: 32'h0};
    end else begin
      cur_q <= nxt_d;
    end
  end

  // Registered outputs.
  assign wrEn               = cur_q.wrEn;
  assign wrAddr             = cur_q.wrAddr;
  assign wrData             = cur_q.wrData;
  assign programStatusFlags = cur_q.flags;
  assign flagsUpdated       = cur_q.upd;
  assign illegalFmt         = cur_q.illegal;
endmodule

// file: tb/compact_alu_op_decode_properties.sv
// Port-level checker for the compact ALU decoder.
`timescale 1ns/1ps
module compact_alu_op_decode_chk (
  // Clock and reset.
  input wire logic        clk,
  input wire logic        rst,
  // Issue and register file.
  input wire logic        instrValid,
  input wire logic [15:0] instr,
  input wire logic        instrReady,
  input wire logic [2:0]  rdAddr,
  input wire logic [2:0]  rsAddr,
  input wire logic [31:0] rdData,
  input wire logic [31:0] rsData,
  input wire logic        wrEn,
  input wire logic [2:0]  wrAddr,
  input wire logic [31:0] wrData,
  // Flags.
  input wire logic [3:0]  programStatusFlags,
  input wire logic        flagsUpdated,
  input wire logic        illegalFmt
);
  logic       tk;
  logic       immF;
  logic       regF;
  logic [1:0] iop;
  logic [3:0] rop;
  // Decode the issued word as the core sees it.
  assign tk = instrValid && instrReady;
  assign immF = instr[15:13] == 3'h1;
  assign regF = instr[15:10] == 6'h10;
  assign iop = instr[12:11];
  assign rop = instr[9:6];
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // Multiply retires late, by operand width, never beyond four cycles.
  sequence mulRetire;
    ##[1:4] (wrEn && flagsUpdated);
  endsequence
  a_imm_dest_addr: assert property (
    tk && immF && iop != 2'h1 |=> wrEn && wrAddr == $past(instr[10:8])) else $error("imm dest");
  a_mov_imm_value: assert property (
    tk && immF && iop == 2'h0 |=> wrData == {24'h0, $past(instr[7:0])}) else $error("mov imm");
  a_cmp_flag_only: assert property (
    tk && immF && iop == 2'h1 |=> !wrEn && flagsUpdated) else $error("cmp imm wrote");
  a_add_imm_sum: assert property (
    tk && immF && iop == 2'h2 |=> wrData == $past(rdData) + {24'h0, $past(instr[7:0])})
    else $error("add imm");
  a_sub_imm_diff: assert property (
    tk && immF && iop == 2'h3 |=> wrData == $past(rdData) - {24'h0, $past(instr[7:0])})
    else $error("sub imm");
  a_reg_read_addr: assert property (
    regF |-> rdAddr == instr[2:0] && rsAddr == instr[5:3]) else $error("reg addr");
  a_test_no_write: assert property (
    tk && regF && rop inside {4'h8, 4'ha, 4'hb} |=> !wrEn && flagsUpdated) else $error("flag op");
  a_mul_retire: assert property (
    tk && regF && rop == 4'hd |-> mulRetire) else $error("mul late");
  a_one_cycle: assert property (
    tk && (immF || regF && rop != 4'hd) |=> flagsUpdated) else $error("no retire");
  a_flags_hold: assert property (
    !flagsUpdated |-> $stable(programStatusFlags)) else $error("flags moved");
endmodule
bind compact_alu_op_decode compact_alu_op_decode_chk u_chk (.clk(clk), .rst(rst),
  .instrValid(instrValid), .instr(instr), .instrReady(instrReady), .rdAddr(rdAddr),
  .rsAddr(rsAddr), .rdData(rdData), .rsData(rsData), .wrEn(wrEn), .wrAddr(wrAddr),
  .wrData(wrData), .programStatusFlags(programStatusFlags), .flagsUpdated(flagsUpdated),
  .illegalFmt(illegalFmt));

// file: tb/testbench.sv
// Self-checking random bench for the compact ALU decoder.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin n_errors++; \
  $display("BAD %s exp %h got %h", nm, e, g); end end
module testbench;
  import alu_pkg::*;
  logic        clk, rst, instrValid, instrReady, wrEn, flagsUpdated, illegalFmt;
  logic [15:0] instr;
  logic [2:0]  rdAddr, rsAddr, wrAddr;
  logic [31:0] rdData, rsData, wrData;
  logic [3:0]  programStatusFlags, fl;
  int          n_errors, n_tests, cyc;
  logic [7:0]  amt[6] = '{8'h0, 8'h1, 8'h1f, 8'h20, 8'h21, 8'hff};
  logic [3:0]  shOp[4] = '{4'h2, 4'h3, 4'h4, 4'h7};
  // Free-running clock.
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  compact_alu_op_decode u_dut (.clk(clk), .rst(rst), .instrValid(instrValid), .instr(instr),
    .instrReady(instrReady), .rdAddr(rdAddr), .rsAddr(rsAddr), .rdData(rdData),
    .rsData(rsData), .wrEn(wrEn), .wrAddr(wrAddr), .wrData(wrData),
    .programStatusFlags(programStatusFlags), .flagsUpdated(flagsUpdated),
    .illegalFmt(illegalFmt));
  // Reference result: {write, N, Z, C, V, value}; logic ops keep C and V.
  function automatic logic [36:0] model(logic [15:0] i, logic [31:0] a, b, logic [3:0] f);
    logic [32:0] s;
    logic [31:0] r, x, y;
    logic        w, c, v, ar, ci, cs;
    logic [7:0]  n;
    c = f[1];
    v = f[0];
    w = 1'b1;
    ar = 1'b1;
    n = b[7:0];
    x = a;
    y = ~b;
    ci = 1'b1;
    r = 32'h0;
    cs = c;
    if (i[15:13] == 3'h1) begin
      y = (i[12:11] == 2'h2) ? {24'h0, i[7:0]} : ~{24'h0, i[7:0]};
      ci = i[12:11] != 2'h2;
      ar = i[12:11] != 2'h0;
      w = i[12:11] != 2'h1;
      r = {24'h0, i[7:0]};
    end else begin
      case (i[9:6])
        4'h5: y = b;
        4'h6: ci = c;
        4'h9: x = 32'h0;
        4'ha: w = 1'b0;
        4'hb: w = 1'b0;
        4'h8: begin
          w  = 1'b0;
          ar = 1'b0;
        end
        default: ar = 1'b0;
      endcase
      case (i[9:6])
        4'h0, 4'h8: r = a & b;
        4'h1: r = a ^ b;
        4'h2: {cs, r} = {1'b0, a} << n;
        4'h3: {r, cs} = {a, 1'b0} >> n;
        4'h4: {r, cs} = $signed({a, 1'b0}) >>> n;
        4'h5: ci = c;
        4'h7: r = (a >> n[4:0]) | (a << (6'd32 - n[4:0]));
        4'hb: y = b;
        4'hc: r = a | b;
        4'hd: r = a * b;
        4'he: r = a & ~b;
        4'hf: r = ~b;
        default: ;
      endcase
      ci = (i[9:6] == 4'hb) ? 1'b0 : ci;
      if (n != 8'h0 && i[9:6] inside {4'h2, 4'h3, 4'h4, 4'h7})
        c = (i[9:6] == 4'h7) ? r[31] : cs;
    end
    s = {1'b0, x} + {1'b0, y} + {32'h0, ci};
    if (ar) begin
      r = s[31:0];
      c = s[32];
      v = (x[31] == y[31]) && (r[31] != x[31]);
    end
    return {w, r[31], r == 32'h0, c, v, r};
  endfunction
  // Multiply latency shrinks when the upper bytes are pure sign.
  function automatic int mlat(logic [31:0] b);
    if (&b[31:8] || ~|b[31:8]) return 1;
    if (&b[31:16] || ~|b[31:16]) return 2;
    if (&b[31:24] || ~|b[31:24]) return 3;
    return 4;
  endfunction
  // Issue one word, then wait a bounded time for its retirement and check it.
  task automatic run(input logic [15:0] i, input logic [31:0] a, b);
    logic [36:0] e;
    logic        bad, imm;
    int          n, lat;
    imm = i[15:13] == 3'h1;
    bad = !imm && i[15:10] != 6'h10;
    lat = (!bad && !imm && i[9:6] == 4'hd) ? mlat(b) : 1;
    e = model(i, a, b, fl);
    `CHK("ready", 1'b1, instrReady)
    instrValid <= 1'b1;
    instr <= i;
    rdData <= a;
    rsData <= b;
    #1;
    if (!bad) `CHK("rdAddr", imm ? i[10:8] : i[2:0], rdAddr)
    if (!bad && !imm) `CHK("rsAddr", i[5:3], rsAddr)
    @(negedge clk);
    instrValid <= 1'b0;
    `CHK("readyBusy", lat == 1, instrReady)
    n = 1;
    while (!(flagsUpdated || illegalFmt) && n < 8) begin
      @(negedge clk);
      n++;
    end
    `CHK("illegal", bad, illegalFmt)
    if (!bad) begin
      `CHK("cycles", lat, n)
      `CHK("wrEn", e[36], wrEn)
      if (e[36]) `CHK("wrAddr", imm ? i[10:8] : i[2:0], wrAddr)
      if (e[36]) `CHK("wrData", e[31:0], wrData)
      `CHK("flags", e[35:32], programStatusFlags)
      fl = e[35:32];
    end
    @(negedge clk);
  endtask
  task automatic tally_and_finish;
    if (n_errors == 0 && n_tests > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // Hang guard, well above the thousand or so cycles the run needs.
  always @(posedge clk) begin
    cyc++;
    if (cyc > 20000) begin
      n_errors++;
      tally_and_finish;
    end
  end
  // Corner cases first, then random words of both formats.
  initial begin
    logic [31:0] a, b;
    cyc = $urandom(32'h9a2c);
    {rst, instrValid, instr, rdData, rsData, fl, n_errors, n_tests, cyc} = '0;
    rst = 1'b1;
    repeat (10) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    `CHK("rstFlags", FLAGS_RESET, programStatusFlags)
    run(16'h2080, 32'h5, 32'h0);
    run(16'h3101, 32'h7fffffff, 32'h0);
    run(16'h3b91, 32'h0, 32'h0);
    run(16'h2a3e, 32'h3e, 32'h0);
    run(16'hffff, 32'h1, 32'h1);
    run(16'h4400, 32'h1, 32'h1);
    // Every shift kind against amounts of zero, inside, at and beyond the word width.
    foreach (amt[k])
      foreach (shOp[j])
        run({6'h10, shOp[j], 6'h0a}, 32'h80000001, {24'h0, amt[k]});
    foreach (amt[k])
      run(16'h4368, 32'h3, 32'h7f << (8 * (k % 4)));
    repeat (400) begin
      a = $urandom;
      b = $urandom;
      if ($urandom % 2) b[7:0] = 8'($urandom % 40);
      if ($urandom % 2) run({3'h1, 13'($urandom)}, a, b);
      else run({6'h10, 10'($urandom)}, a, b);
    end
    tally_and_finish;
  end
endmodule
